// *** design/pib_pkg.sv ***
// Constants and types shared by the parallel I/O bus bridge
package pib_pkg;

   // Host address decode
   localparam int unsigned ADDR_W        = 16;
   localparam int unsigned BLOCK_LSB     = 6;
   localparam int unsigned BLOCK_W       = 10;
   localparam int unsigned PORT_W        = 6;
   localparam int unsigned DATA_W        = 8;

   // Option strap positions
   localparam int unsigned OPT_W         = 3;
   localparam int unsigned OPT_MEMEX     = 0;
   localparam int unsigned OPT_WAIT      = 1;
   localparam int unsigned OPT_BUSAK     = 2;

   // Wait state length in host clock cycles
   localparam int unsigned WAIT_CYCLES   = 1;

   // AHB register map (byte addresses)
   localparam logic [11:0] REG_CTRL      = 12'h000;
   localparam logic [11:0] REG_STATUS    = 12'h004;
   localparam logic [11:0] REG_LAST      = 12'h008;
   localparam int unsigned REG_AW        = 12;

   // CTRL fields
   localparam int unsigned CTRL_ENABLE   = 0;
   localparam int unsigned CTRL_SOFT_RST = 1;
   localparam logic [1:0]  CTRL_RESET    = 2'h1;

   // STATUS fields
   localparam int unsigned ST_SEL        = 0;
   localparam int unsigned ST_CRESET     = 1;
   localparam int unsigned ST_WAIT       = 2;
   localparam int unsigned ST_OPT_LSB    = 4;
   localparam int unsigned ST_STRAP_LSB  = 8;

   // LAST fields
   localparam int unsigned LAST_PORT_LSB = 0;
   localparam int unsigned LAST_DATA_LSB = 8;
   localparam int unsigned LAST_WR       = 16;

   // AHB encodings
   localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0]  HTRANS_SEQ    = 2'h3;
   localparam logic        HRESP_OKAY    = 1'h0;

   // Cable access phase
   typedef enum logic [1:0] {
      PIB_IDLE,
      PIB_WAIT,
      PIB_ACTIVE
   } pib_state_t;

endpackage : pib_pkg

// *** design/pib_bridge.sv ***
// Host backplane to parallel I/O cable bridge with AHB-Lite status registers
`timescale 1ns/1ps

module pib_bridge
   import pib_pkg::*;
(
   input  wire logic                  hclk,
   input  wire logic                  hresetn,
   // AHB-Lite slave
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic      [31:0]           hrdata,
   output logic                       hreadyout,
   output logic                       hresp,
   // Host backplane memory cycles
   input  wire logic [ADDR_W-1:0]     host_addr,
   input  wire logic                  host_mreq_n,
   input  wire logic                  host_rd_n,
   input  wire logic                  host_wr_n,
   input  wire logic                  host_refresh_n,
   input  wire logic                  host_memex_n,
   input  wire logic                  host_busak_n,
   input  wire logic                  host_sysreset_n,
   input  wire logic [DATA_W-1:0]     host_data_in,
   output logic      [DATA_W-1:0]     host_data_out,
   output logic                       host_data_oe,
   output logic                       host_wait_n,
   output logic                       host_status0_n_out,
   output logic                       host_status0_n_oe,
   // Straps, high means jumper installed
   input  wire logic [BLOCK_W-1:0]    block_address_straps,
   input  wire logic [OPT_W-1:0]      option_straps,
   // Cable side
   output logic      [PORT_W-1:0]     cable_port_addr,
   output logic                       cable_read_strobe,
   output logic                       cable_write_strobe,
   input  wire logic [DATA_W-1:0]     cable_data_in,
   output logic      [DATA_W-1:0]     cable_data_out,
   output logic                       cable_data_oe
);

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers

   localparam int unsigned SYNC_W = ADDR_W + 6 + DATA_W + BLOCK_W + OPT_W + DATA_W;

   logic [SYNC_W-1:0] sync1_r;
   logic [SYNC_W-1:0] sync2_r;
   logic [SYNC_W-1:0] sync_in;

   assign sync_in = {host_addr, host_mreq_n, host_rd_n, host_wr_n, host_refresh_n,
                     host_memex_n, host_busak_n, host_data_in, block_address_straps,
                     option_straps, cable_data_in};

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_r <= '1;
         sync2_r <= '1;
      end else begin
         sync1_r <= sync_in;
         sync2_r <= sync1_r;
      end
   end

   // Reset pin kept in its own pair; resets low on async reset
   logic rst_sync1_r;
   logic rst_sync2_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rst_sync1_r <= 1'b0;
         rst_sync2_r <= 1'b0;
      end else begin
         rst_sync1_r <= host_sysreset_n;
         rst_sync2_r <= rst_sync1_r;
      end
   end

   logic [ADDR_W-1:0]  s_addr;
   logic               s_mreq_n;
   logic               s_rd_n;
   logic               s_wr_n;
   logic               s_refresh_n;
   logic               s_memex_n;
   logic               s_busak_n;
   logic [DATA_W-1:0]  s_host_data;
   logic [BLOCK_W-1:0] s_straps;
   logic [OPT_W-1:0]   s_opts;
   logic [DATA_W-1:0]  s_cable_data;

   assign {s_addr, s_mreq_n, s_rd_n, s_wr_n, s_refresh_n, s_memex_n, s_busak_n,
           s_host_data, s_straps, s_opts, s_cable_data} = sync2_r;

   ////////////////////////////////////////////////////////////////////////////
   // Software control register

   logic [1:0] ctrl_r;

   ////////////////////////////////////////////////////////////////////////////
   // Address decode

   logic [BLOCK_W-1:0] block_pattern;
   logic               addr_match;
   logic               memex_ok;
   logic               host_rd;
   logic               host_wr;
   logic               sel;
   logic               cable_reset;

   assign block_pattern = ~s_straps;
   assign addr_match    = (s_addr[ADDR_W-1:BLOCK_LSB] == block_pattern);
   assign memex_ok      = !s_opts[OPT_MEMEX] || !s_memex_n;
   assign host_rd       = !s_mreq_n && !s_rd_n;
   assign host_wr       = !s_mreq_n && !s_wr_n;
   assign sel           = addr_match && s_refresh_n && memex_ok
                          && ctrl_r[CTRL_ENABLE] && (host_rd || host_wr);
   assign cable_reset   = !rst_sync2_r || ctrl_r[CTRL_SOFT_RST];

   ////////////////////////////////////////////////////////////////////////////
   // Access sequencing and wait state

   pib_state_t state_r;
   pib_state_t state_nxt;
   logic [1:0] wait_cnt_r;

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         PIB_IDLE: begin
            if (sel) begin
               state_nxt = s_opts[OPT_WAIT] ? PIB_WAIT : PIB_ACTIVE;
            end
         end
         PIB_WAIT: begin
            if (!sel) begin
               state_nxt = PIB_IDLE;
            end else if (wait_cnt_r == 2'(WAIT_CYCLES - 1)) begin
               state_nxt = PIB_ACTIVE;
            end
         end
         PIB_ACTIVE: begin
            if (!sel) begin
               state_nxt = PIB_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r <= PIB_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wait_cnt_r <= 2'h0;
      end else if (state_r == PIB_WAIT) begin
         wait_cnt_r <= wait_cnt_r + 2'h1;
      end else begin
         wait_cnt_r <= 2'h0;
      end
   end

   // One host clock of wait request per selected access
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         host_wait_n <= 1'b1;
      end else begin
         host_wait_n <= !(state_nxt == PIB_WAIT);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Cable control strobes and port address

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cable_read_strobe  <= 1'b1;
         cable_write_strobe <= 1'b1;
      end else if (cable_reset) begin
         cable_read_strobe  <= 1'b1;
         cable_write_strobe <= 1'b1;
      end else begin
         cable_read_strobe  <= sel && host_rd && (state_nxt == PIB_ACTIVE);
         cable_write_strobe <= sel && host_wr && (state_nxt == PIB_ACTIVE);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cable_port_addr <= '0;
      end else begin
         cable_port_addr <= s_addr[PORT_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Data transceiver steering

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cable_data_oe  <= 1'b0;
         cable_data_out <= '0;
         host_data_oe   <= 1'b0;
         host_data_out  <= '0;
      end else begin
         cable_data_oe  <= sel && host_wr && !cable_reset;
         cable_data_out <= s_host_data;
         host_data_oe   <= sel && host_rd && !cable_reset;
         host_data_out  <= s_cable_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus acknowledge onto status 0

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         host_status0_n_out <= 1'b1;
         host_status0_n_oe  <= 1'b0;
      end else begin
         host_status0_n_out <= s_busak_n;
         host_status0_n_oe  <= s_opts[OPT_BUSAK];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Last access capture

   logic [PORT_W-1:0] last_port_r;
   logic [DATA_W-1:0] last_data_r;
   logic              last_wr_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         last_port_r <= '0;
         last_data_r <= '0;
         last_wr_r   <= 1'b0;
      end else if (cable_read_strobe && !cable_write_strobe) begin
         last_port_r <= cable_port_addr;
         last_data_r <= s_cable_data;
         last_wr_r   <= 1'b0;
      end else if (cable_write_strobe && !cable_read_strobe) begin
         last_port_r <= cable_port_addr;
         last_data_r <= cable_data_out;
         last_wr_r   <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave

   logic              ahb_take;
   logic              dp_wr_r;
   logic [REG_AW-1:0] dp_addr_r;

   assign ahb_take = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_wr_r   <= 1'b0;
         dp_addr_r <= '0;
      end else begin
         dp_wr_r   <= ahb_take && hwrite;
         dp_addr_r <= haddr[REG_AW-1:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_r <= CTRL_RESET;
      end else if (dp_wr_r && dp_addr_r == REG_CTRL) begin
         ctrl_r <= hwdata[1:0];
      end
   end

   logic [31:0] rd_mux;

   always_comb begin
      rd_mux = 32'h0;
      unique case (haddr[REG_AW-1:0])
         REG_CTRL: begin
            rd_mux[1:0] = ctrl_r;
         end
         REG_STATUS: begin
            rd_mux[ST_SEL]    = sel;
            rd_mux[ST_CRESET] = cable_reset;
            rd_mux[ST_WAIT]   = !host_wait_n;
            rd_mux[ST_OPT_LSB +: OPT_W]     = s_opts;
            rd_mux[ST_STRAP_LSB +: BLOCK_W] = s_straps;
         end
         REG_LAST: begin
            rd_mux[LAST_PORT_LSB +: PORT_W] = last_port_r;
            rd_mux[LAST_DATA_LSB +: DATA_W] = last_data_r;
            rd_mux[LAST_WR]                 = last_wr_r;
         end
         default: begin
            rd_mux = 32'h0;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0;
      end else if (ahb_take && !hwrite) begin
         hrdata <= rd_mux;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= HRESP_OKAY;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= HRESP_OKAY;
      end
   end

endmodule : pib_bridge

// *** bench/pib_chk.sv ***
// Port-level checks on the bridge
`timescale 1ns/1ps
module pib_chk
   import pib_pkg::*;
(
   input wire logic               hclk,
   input wire logic               hresetn,
   input wire logic [ADDR_W-1:0]  host_addr,
   input wire logic               host_mreq_n,
   input wire logic               host_rd_n,
   input wire logic               host_wr_n,
   input wire logic               host_refresh_n,
   input wire logic               host_memex_n,
   input wire logic               host_busak_n,
   input wire logic               host_sysreset_n,
   input wire logic               host_data_oe,
   input wire logic               host_wait_n,
   input wire logic               host_status0_n_out,
   input wire logic               host_status0_n_oe,
   input wire logic [BLOCK_W-1:0] block_address_straps,
   input wire logic [OPT_W-1:0]   option_straps,
   input wire logic [PORT_W-1:0]  cable_port_addr,
   input wire logic               cable_read_strobe,
   input wire logic               cable_write_strobe,
   input wire logic               cable_data_oe
);
   logic [2:0] up_r;
   wire        hit    = host_addr[15:6] == ~block_address_straps && host_refresh_n
                        && !host_mreq_n;
   wire        rd_hit = hit && !host_rd_n;
   wire        wr_hit = hit && !host_wr_n;
   wire        one    = cable_read_strobe ^ cable_write_strobe;
   wire        up     = up_r == 3'h7;

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // Settling time after reset for the synchronised paths
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         up_r <= 3'h0;
      else if (!up)
         up_r <= up_r + 3'h1;

   ////////////////////////////////////////////////////////////////////////////
   a_read_from_host: assert property (
      cable_read_strobe && !cable_write_strobe |-> $past(rd_hit, 3))
      else $error("read strobe without selected read");
   a_write_from_host: assert property (
      cable_write_strobe && !cable_read_strobe |-> $past(wr_hit, 3))
      else $error("write strobe without selected write");
   a_memex_gate: assert property (
      one && option_straps[OPT_MEMEX] |-> !$past(host_memex_n, 3))
      else $error("strobe while memex high");
   a_cable_oe_sel: assert property (cable_data_oe |-> $past(wr_hit, 3))
      else $error("cable drivers on without selected write");
   a_host_oe_sel: assert property (host_data_oe |-> $past(rd_hit, 3))
      else $error("host drivers on without selected read");
   a_reset_code: assert property (
      !host_sysreset_n [*3] |=> cable_read_strobe && cable_write_strobe && !cable_data_oe)
      else $error("system reset not coded on cable");
   a_wait_single: assert property (
      $fell(host_wait_n) |-> option_straps[OPT_WAIT] ##1 host_wait_n)
      else $error("wait request not one cycle");
   a_wait_strobe: assert property ($fell(host_wait_n) |=> one)
      else $error("no strobe after wait state");
   a_port_follows: assert property (
      (up && $stable(host_addr)) [*4] |-> cable_port_addr == host_addr[5:0])
      else $error("port address not passed");
   a_status0_pass: assert property (
      (up && $stable(option_straps) && $stable(host_busak_n)) [*4]
      |-> host_status0_n_oe == option_straps[OPT_BUSAK]
      && (!host_status0_n_oe || host_status0_n_out == host_busak_n))
      else $error("status0 link wrong");
endmodule : pib_chk

bind pib_bridge pib_chk u_chk (
   .hclk, .hresetn, .host_addr, .host_mreq_n, .host_rd_n, .host_wr_n, .host_refresh_n,
   .host_memex_n, .host_busak_n, .host_sysreset_n, .host_data_oe, .host_wait_n,
   .host_status0_n_out, .host_status0_n_oe, .block_address_straps, .option_straps,
   .cable_port_addr, .cable_read_strobe, .cable_write_strobe, .cable_data_oe
);

// *** bench/pib_periph.sv ***
// Cable-side ports answering the bridge's strobes
`timescale 1ns/1ps
module pib_periph
   import pib_pkg::*;
(
   input  wire logic              hclk,
   input  wire logic [PORT_W-1:0] cable_port_addr,
   input  wire logic              cable_read_strobe,
   input  wire logic              cable_write_strobe,
   input  wire logic [DATA_W-1:0] cable_data_out,
   input  wire logic              cable_data_oe,
   output logic      [DATA_W-1:0] cable_data_in
);
   logic [DATA_W-1:0] mem [64];
   logic [DATA_W-1:0] last_r = 8'h00;
   logic              wr_r   = 1'h0;
   logic [PORT_W-1:0] port_r;
   logic [DATA_W-1:0] data_r;
   wire               rd_on  = cable_read_strobe && !cable_write_strobe;

   initial foreach (mem[i]) mem[i] = 8'h00;
   // Released lines toggle so stale data never looks valid
   assign cable_data_in = rd_on ? mem[cable_port_addr] : ~last_r;
   always @(posedge hclk) begin
      last_r <= cable_data_in;
      wr_r   <= cable_write_strobe && !cable_read_strobe;
      port_r <= cable_port_addr;
      data_r <= cable_data_oe ? cable_data_out : ~cable_data_out;
      if (cable_read_strobe && cable_write_strobe)
         foreach (mem[i]) mem[i] <= 8'h00;
      else if (wr_r && !cable_write_strobe)
         mem[port_r] <= data_r;
   end
endmodule : pib_periph

// *** bench/pib_bridge_tb.sv ***
// Self-checking bench for the parallel I/O bus bridge
`timescale 1ns/1ps
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin failures++; \
   $display("ERROR %s expected %0h seen %0h", nm, e, s); end end
module pib_bridge_tb import pib_pkg::*;;
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
   logic [31:0] haddr = '0, hwdata = '0, hrdata;
   logic [1:0]  htrans = '0;
   logic [2:0]  hsize = 3'h2;
   logic [15:0] host_addr = '0;
   logic        host_mreq_n = 1, host_rd_n = 1, host_wr_n = 1, host_refresh_n = 1;
   logic        host_memex_n = 1, host_busak_n = 1, host_sysreset_n = 1;
   logic [7:0]  host_data_in = '0, host_data_out, cable_data_in, cable_data_out;
   logic        host_data_oe, host_wait_n, host_status0_n_out, host_status0_n_oe;
   logic [9:0]  block_address_straps = '0;
   logic [2:0]  option_straps = '0;
   logic [5:0]  cable_port_addr;
   logic        cable_read_strobe, cable_write_strobe, cable_data_oe;
   logic [8:0]  rdv;
   logic [7:0]  shadow [64];
   int          failures = 0, compares = 0, nrd, nwr, nwt;

   pib_bridge dut (.*, .hready(hreadyout));
   pib_periph u_per (.*);

   always #5 hclk = ~hclk;

   ////////////////////////////////////////////////////////////////////////////
   task conclude;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : conclude

   task ahb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
      int n;
      n = 0;
      hsel <= 1'h1;
      haddr <= {20'h0, a};
      hwrite <= w;
      htrans <= HTRANS_NONSEQ;
      do @(posedge hclk); while (!hreadyout && ++n < 50);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (!hreadyout && ++n < 50);
      rd = hrdata;
      `CHK("hresp", HRESP_OKAY, hresp)
      hsel <= 1'h0;
      @(posedge hclk);
      if (n >= 50) begin
         failures++;
         conclude();
      end
   endtask : ahb

   task mon(input int n);
      repeat (n) begin
         @(negedge hclk);
         nrd += int'(cable_read_strobe && !cable_write_strobe);
         nwr += int'(cable_write_strobe && !cable_read_strobe);
         nwt += int'(!host_wait_n);
         rdv = {host_data_oe, host_data_out & {8{host_data_oe}}};
      end
      @(posedge hclk);
   endtask : mon

   function automatic logic exp_sel(input logic [15:0] a, input logic [9:0] st,
                                    input logic [2:0] op, input logic rf_n, input logic mx_n);
      return a[15:6] == ~st && rf_n && (!op[OPT_MEMEX] || !mx_n);
   endfunction : exp_sel

   task cyc(input logic wr, input logic [15:0] a, input logic [7:0] d, input logic sel,
            input logic wt);
      nrd = 0;
      nwr = 0;
      nwt = 0;
      host_addr <= a;
      host_data_in <= d;
      host_mreq_n <= 1'h0;
      host_rd_n <= wr;
      host_wr_n <= !wr;
      mon(9);
      `CHK("read data", (sel && !wr) ? {1'h1, shadow[a[5:0]]} : 9'h0, rdv)
      host_mreq_n <= 1'h1;
      host_rd_n <= 1'h1;
      host_wr_n <= 1'h1;
      mon(6);
      if (sel && wr)
         shadow[a[5:0]] = d;
      `CHK("strobes", {sel && !wr, sel && wr}, {nrd != 0, nwr != 0})
      `CHK("wait cycles", (sel && wt) ? 1 : 0, nwt)
      `CHK("port data", shadow[a[5:0]], u_per.mem[a[5:0]])
   endtask : cyc

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] r;
      logic [15:0] a;
      logic [9:0]  st;
      logic [2:0]  op;
      logic        wr, sel;
      logic [15:0] ca [4];
      ca = '{16'h003f, 16'hffc0, 16'h0040, 16'hffbf};
      void'($urandom(32'h1cf3));
      foreach (shadow[i]) shadow[i] = 8'h00;
      repeat (10) @(posedge hclk);
      hresetn <= 1'h1;
      repeat (6) @(posedge hclk);
      ahb(1'h0, REG_CTRL, 32'h0, r);
      `CHK("ctrl reset", 32'h1, r & 32'h3)
      ahb(1'h0, 12'h00c, 32'h0, r);
      `CHK("unmapped", 32'h0, r)
      $display("test registers done");
      for (int k = 0; k < 48; k++) begin
         st = 10'($urandom);
         op = 3'($urandom);
         a = 16'($urandom);
         if (k < 4) begin
            st = k[0] ? 10'h000 : 10'h3ff;
            op = 3'h0;
            a = ca[k];
         end else if ($urandom % 2)
            a[15:6] = ~st;
         block_address_straps <= st;
         option_straps <= op;
         host_memex_n <= 1'($urandom);
         host_refresh_n <= k < 4 || ($urandom % 5) != 0;
         host_busak_n <= 1'($urandom);
         wr = 1'($urandom);
         repeat (5) @(posedge hclk);
         sel = exp_sel(a, st, op, host_refresh_n, host_memex_n);
         cyc(wr, a, 8'($urandom), sel, op[OPT_WAIT]);
         `CHK("status0", {op[2], op[2] & host_busak_n},
              {host_status0_n_oe, host_status0_n_oe & host_status0_n_out})
         if (sel) begin
            ahb(1'h0, REG_LAST, 32'h0, r);
            `CHK("last port", {wr, a[5:0]}, {r[16], r[5:0]})
         end
      end
      ahb(1'h0, REG_STATUS, 32'h0, r);
      `CHK("status straps", st, r[17:8])
      $display("test random cycles done");
      option_straps <= 3'h0;
      host_refresh_n <= 1'h1;
      ahb(1'h1, REG_CTRL, 32'h0, r);
      repeat (3) @(posedge hclk);
      cyc(1'h1, {~st, 6'h05}, 8'h3c, 1'h0, 1'h0);
      ahb(1'h1, REG_CTRL, 32'h1, r);
      cyc(1'h1, {~st, 6'h05}, 8'h5a, 1'h1, 1'h0);
      ahb(1'h1, REG_CTRL, 32'h3, r);
      repeat (5) @(negedge hclk);
      `CHK("soft reset", 2'h3, {cable_read_strobe, cable_write_strobe})
      `CHK("cleared", 8'h00, u_per.mem[5])
      @(posedge hclk);
      ahb(1'h0, REG_STATUS, 32'h0, r);
      `CHK("status reset", 1'h1, r[ST_CRESET])
      ahb(1'h1, REG_CTRL, 32'h1, r);
      repeat (5) @(posedge hclk);
      cyc(1'h1, {~st, 6'h09}, 8'ha5, 1'h1, 1'h0);
      host_sysreset_n <= 1'h0;
      repeat (5) @(negedge hclk);
      `CHK("sysreset", 2'h3, {cable_read_strobe, cable_write_strobe})
      `CHK("sys cleared", 8'h00, u_per.mem[9])
      @(posedge hclk);
      host_sysreset_n <= 1'h1;
      foreach (shadow[i]) shadow[i] = 8'h00;
      repeat (6) @(posedge hclk);
      cyc(1'h0, {~st, 6'h09}, 8'h00, 1'h1, 1'h0);
      $display("test resets done");
      conclude();
   end
endmodule : pib_bridge_tb
